// File: include/acc_consts.svh
// What this block does
// RULE1: each conversion takes sixteen converter clocks
// RULE2: register write starts conversion next converter tick
// RULE3: finished conversion stores 8-bit result
// RULE4: channel field routes one of four inputs
// RULE5: out-of-range inputs saturate to ff or 00
// RULE6: continuous mode repeats, overwriting result each time
// RULE7: flag set per conversion, cleared by data read
// RULE8: interrupt enabled: raise interrupt, flag stays clear
// RULE9: software discards conversion interrupted by write
// RULE10: selected pin forced to converter input
// RULE11: used pin reads zero or data latch
// RULE12: converts in wait; interrupt can wake
// RULE13: software powers off converter before wait
// RULE14: stop aborts conversion, resumes after stop
// RULE15: software ignores first conversion after stop
// RULE16: five-bit channel field, all ones off, reset
// RULE17: prescaler divides by 1,2,4,8 or 16
// RULE18: data read or control write clears interrupt
// RULE19: single mode: one conversion per control write
// RULE20: result changes only when a conversion completes
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// ==========================================================
// register map
`define ACC_ADDR_CSR   8'h3c
`define ACC_ADDR_DATA  8'h3e
`define ACC_ADDR_CLK   8'h3f
`define ACC_ADDR_PORT  8'h00
`define ACC_ADDR_DDR   8'h04

// ==========================================================
// control/status fields
`define ACC_CSR_DONE   7
`define ACC_CSR_IEN    6
`define ACC_CSR_CONT   5
`define ACC_CSR_CH_HI  4
`define ACC_CSR_CH_LO  0
`define ACC_CH_OFF     5'h1f
`define ACC_CH_PINS    5'h04
`define ACC_PRE_HI     2
`define ACC_PRE_TOP    2
`define ACC_PRE_LO     0
`define ACC_PRE_RESET  3'h0

// ==========================================================
// conversion timing
`define ACC_DIV16_LAST 4'hf
`define ACC_DIV_ONE    4'h1
`define ACC_CONV_LAST  4'hf
`define ACC_SAR_BITS   4'h8
`define ACC_SAR_TOP    4'h7
`define ACC_SAR_MSB    8'h80
`define ACC_STEP_ONE   4'h1

`endif

// File: include/acc_pkg.sv
package acc_pkg;

    // ==========================================================
    // conversion sequencer states, gray along idle-armed-convert
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_ARMED = 2'h1,
        ST_CONV  = 2'h3
    } acc_state_t;

    // ==========================================================
    // all state of the block
    typedef struct packed {
        acc_state_t  state;
        logic [4:0]  ch;
        logic        ien;
        logic        cont;
        logic [2:0]  pre;
        logic [7:0]  result;
        logic        done_flag;
        logic        irq;
        logic [3:0]  div_cnt;
        logic        tick;
        logic [3:0]  step;
        logic [7:0]  sar;
        logic [7:0]  dac;
        logic [3:0]  latch;
        logic [3:0]  ddr;
        logic [3:0]  oe;
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic [3:0]  s3;
        logic [3:0]  pin_val;
        logic [7:0]  rdata;
        logic        en;
    } acc_regs_t;

endpackage

// File: rtl/acc_top.sv
`timescale 1ns/1ps
`include "acc_consts.svh"

module acc_top (
    input  wire logic                CORE_CLK,
    input  wire logic                NRST,
    input  wire logic [7:0]          ADDR,
    input  wire logic [7:0]          WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output logic      [7:0]          RDATA,
    input  wire logic                STOP_MODE,
    input  wire logic                COMP_HI,
    output logic      [7:0]          SAR_CODE,
    output logic      [4:0]          CHAN_SEL,
    output logic                     CONV_EN,
    output logic                     CONV_IRQ,
    input  wire logic [3:0]          PIN_IN,
    output logic      [3:0]          PIN_OUT,
    output logic      [3:0]          PIN_OE,
    input  wire acc_pkg::acc_state_t STATE_UNUSED_NONE
);
    import acc_pkg::*;

    // ==========================================================
    // decoding helpers

    // one-hot mask of the port pin that the converter owns
    function automatic logic [3:0] sel_mask(input logic [4:0] ch);
        logic [3:0] m;
        m = 4'h0;
        if (ch < `ACC_CH_PINS) begin
            m = 4'h1 << ch[1:0]; // RULE4
        end
        return m;
    endfunction

    // last count of the prescaler for a given field value
    function automatic logic [3:0] div_last(input logic [2:0] pre);
        logic [3:0] d;
        d = `ACC_DIV16_LAST;
        if (!pre[`ACC_PRE_TOP]) begin
            d = (`ACC_DIV_ONE << pre[1:0]) - `ACC_DIV_ONE; // RULE17
        end
        return d;
    endfunction

    acc_regs_t r_reg;
    acc_regs_t r_next;

    // ==========================================================
    // next-state logic
    always_comb begin
        logic       wr_csr;
        logic       rd_data;
        logic [2:0] bit_idx;
        logic [3:0] own;
        wr_csr  = 1'b0;
        rd_data = 1'b0;
        bit_idx = 3'h0;
        own     = 4'h0;
        r_next  = r_reg;

        // pins: three stages, a change is taken once the last two agree
        r_next.s1 = PIN_IN;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        if (r_reg.s2 == r_reg.s3) begin
            r_next.pin_val = r_reg.s3;
        end

        // converter clock: one-cycle tick, divider held at zero while stopped
        r_next.tick = 1'b0;
        if (STOP_MODE) begin
            r_next.div_cnt = 4'h0; // RULE14
        end else if (r_reg.div_cnt >= div_last(r_reg.pre)) begin
            r_next.div_cnt = 4'h0;
            r_next.tick    = 1'b1; // RULE17
        end else begin
            r_next.div_cnt = r_reg.div_cnt + `ACC_DIV_ONE;
        end

        // ======================================================
        // register writes and read side effects
        // clears come first so that a completion in the same cycle wins
        if (WR) begin
            unique case (ADDR)
                `ACC_ADDR_CSR: begin
                    // the flag bit is read-only and ignored on write
                    r_next.ien  = WDATA[`ACC_CSR_IEN];
                    r_next.cont = WDATA[`ACC_CSR_CONT];
                    r_next.ch   = WDATA[`ACC_CSR_CH_HI:`ACC_CSR_CH_LO]; // RULE16
                    r_next.irq  = 1'b0; // RULE18
                    wr_csr      = 1'b1;
                end
                `ACC_ADDR_CLK: begin
                    r_next.pre = WDATA[`ACC_PRE_HI:`ACC_PRE_LO];
                end
                `ACC_ADDR_PORT: begin
                    r_next.latch = WDATA[3:0];
                end
                `ACC_ADDR_DDR: begin
                    r_next.ddr = WDATA[3:0];
                end
                default: begin
                end
            endcase
        end
        if (RD && (ADDR == `ACC_ADDR_DATA)) begin
            rd_data = 1'b1;
        end
        if (rd_data) begin
            r_next.done_flag = 1'b0; // RULE7
            r_next.irq       = 1'b0; // RULE18
        end

        // ======================================================
        // conversion sequencer
        unique case (r_reg.state)
            ST_IDLE: begin
            end
            ST_ARMED: begin
                // the first converter edge after arming starts sampling
                if (r_reg.tick && !STOP_MODE) begin
                    r_next.state = ST_CONV; // RULE2
                    r_next.step  = 4'h0;
                    r_next.sar   = 8'h00;
                    r_next.dac   = `ACC_SAR_MSB;
                end
            end
            ST_CONV: begin
                if (STOP_MODE) begin
                    // abort without touching the result; rearm for resume
                    r_next.state = ST_ARMED; // RULE14
                    r_next.dac   = 8'h00;
                end else if (r_reg.tick) begin
                    if (r_reg.step < `ACC_SAR_BITS) begin
                        // comparator high means input at or above the trial
                        // code, so rails beyond the supplies give ff or 00
                        bit_idx = 3'(`ACC_SAR_TOP - r_reg.step);
                        r_next.sar[bit_idx] = COMP_HI; // RULE5
                        r_next.dac = r_next.sar
                                   | (`ACC_SAR_MSB >> (r_reg.step + `ACC_STEP_ONE));
                    end
                    r_next.step = r_reg.step + `ACC_STEP_ONE;
                    if (r_reg.step == `ACC_CONV_LAST) begin // RULE1
                        r_next.result = r_reg.sar; // RULE3 RULE20
                        if (r_reg.ien) begin
                            r_next.irq = 1'b1; // RULE8 RULE12
                        end else begin
                            r_next.done_flag = 1'b1; // RULE7
                        end
                        if (r_reg.cont) begin
                            r_next.step = 4'h0; // RULE6
                            r_next.sar  = 8'h00;
                            r_next.dac  = `ACC_SAR_MSB;
                        end else begin
                            r_next.state = ST_IDLE; // RULE19
                            r_next.dac   = 8'h00;
                        end
                    end
                end
            end
            default: begin
                r_next.state = ST_IDLE;
            end
        endcase

        // a control write aborts whatever runs and arms a fresh start unless the channel is off;
        // a half-done result is dropped, never stored
        if (wr_csr) begin
            r_next.dac  = 8'h00;
            r_next.step = 4'h0;
            if (r_next.ch == `ACC_CH_OFF) begin
                r_next.state = ST_IDLE; // RULE16
            end else begin
                r_next.state = ST_ARMED; // RULE2 RULE20
            end
        end
        r_next.en = (r_next.ch != `ACC_CH_OFF);

        // with interrupts on, the flag is neither set nor shown
        if (r_next.ien) begin
            r_next.done_flag = 1'b0; // RULE8
        end

        // ======================================================
        // pin ownership: the converter's pin is never driven
        own      = sel_mask(r_next.ch);
        r_next.oe = r_next.ddr & ~own; // RULE10

        // ======================================================
        // read data, valid only in the cycle after the strobe
        r_next.rdata = 8'h00;
        if (RD) begin
            unique case (ADDR)
                `ACC_ADDR_CSR: begin
                    r_next.rdata = {r_reg.done_flag, r_reg.ien, r_reg.cont, r_reg.ch};
                end
                `ACC_ADDR_DATA: begin
                    r_next.rdata = r_reg.result;
                end
                `ACC_ADDR_CLK: begin
                    r_next.rdata = {5'h00, r_reg.pre};
                end
                `ACC_ADDR_PORT: begin
                    // owned pins give the latch if output, else zero
                    r_next.rdata = {4'h0, (r_reg.ddr & r_reg.latch)
                                   | (~r_reg.ddr & ~sel_mask(r_reg.ch)
                                      & r_reg.pin_val)}; // RULE11
                end
                `ACC_ADDR_DDR: begin
                    r_next.rdata = {4'h0, r_reg.ddr};
                end
                default: begin
                    r_next.rdata = 8'h00;
                end
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            r_reg       <= '0;
            r_reg.ch    <= `ACC_CH_OFF; // RULE16
            r_reg.pre   <= `ACC_PRE_RESET;
            r_reg.state <= ST_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // outputs, each straight from the state register
    assign RDATA    = r_reg.rdata;
    assign SAR_CODE = r_reg.dac;
    assign CHAN_SEL = r_reg.ch; // RULE4
    assign CONV_EN  = r_reg.en;
    assign CONV_IRQ = r_reg.irq;
    assign PIN_OUT  = r_reg.latch;
    assign PIN_OE   = r_reg.oe;

endmodule

// File: verification/acc_properties.sv
`timescale 1ns/1ps
module acc_properties (
    input wire logic       CORE_CLK,
    input wire logic       NRST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic       STOP_MODE,
    input wire logic [7:0] SAR_CODE,
    input wire logic [4:0] CHAN_SEL,
    input wire logic       CONV_EN,
    input wire logic       CONV_IRQ,
    input wire logic [3:0] PIN_OUT,
    input wire logic [3:0] PIN_OE
);
    logic [7:0] wdata_q;
    logic       clear_q;

    // ======================================
    // helpers: what the last edge carried
    always_ff @(posedge CORE_CLK) begin
        wdata_q <= WDATA;
        clear_q <= (RD && ADDR == 8'h3e) || (WR && ADDR == 8'h3c);
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence csr_write;
        WR && ADDR == 8'h3c;
    endsequence
    sequence port_write;
        WR && ADDR == 8'h00;
    endsequence

    // ======================================
    // checks
    chan_write_a:
        assert property (csr_write |=> CHAN_SEL == wdata_q[4:0])
        else $error("channel field not taken from control write");
    power_state_a:
        assert property (CONV_EN == (CHAN_SEL != 5'h1f))
        else $error("power state disagrees with channel field");
    pin_owned_a:
        assert property (CHAN_SEL < 5'h04 |-> !PIN_OE[CHAN_SEL[1:0]])
        else $error("selected pin still driven by port");
    latch_write_a:
        assert property (port_write |=> PIN_OUT == wdata_q[3:0])
        else $error("port latch not updated");
    sar_off_a:
        assert property (!CONV_EN |-> SAR_CODE == 8'h00)
        else $error("trial code while powered off");
    sar_start_a:
        assert property (SAR_CODE != 8'h00 && $past(SAR_CODE) == 8'h00 |-> SAR_CODE == 8'h80)
        else $error("conversion did not start at midscale");
    irq_fall_a:
        assert property ($fell(CONV_IRQ) |-> clear_q)
        else $error("interrupt dropped without read or write");
    stop_idle_a:
        assert property (STOP_MODE [*2] |-> SAR_CODE == 8'h00)
        else $error("conversion running in stop");
endmodule

bind acc_top acc_properties u_props (
    .CORE_CLK (CORE_CLK), .NRST (NRST), .ADDR (ADDR), .WDATA (WDATA), .WR (WR), .RD (RD),
    .STOP_MODE (STOP_MODE), .SAR_CODE (SAR_CODE), .CHAN_SEL (CHAN_SEL), .CONV_EN (CONV_EN),
    .CONV_IRQ (CONV_IRQ), .PIN_OUT (PIN_OUT), .PIN_OE (PIN_OE)
);

// File: verification/acc_comparator_model.sv
`timescale 1ns/1ps
module acc_comparator_model (
    input  wire logic       clk,
    input  wire logic [7:0] sar_code,
    input  wire logic [4:0] chan_sel,
    input  wire logic       conv_en,
    input  int              level [4],
    output logic            comp_hi
);
    int   vin;
    logic wobble = 1'b0;

    // powered off the comparator output is junk, so it toggles
    always_ff @(posedge clk) wobble <= ~wobble;

    always_comb begin
        case (chan_sel)
            5'h1d: vin = 255;
            5'h1e: vin = 0;
            default: vin = (chan_sel < 5'h04) ? level[chan_sel[1:0]] : 0;
        endcase
        if (vin > 255) vin = 255;
        if (vin < 0) vin = 0;
        comp_hi = conv_en ? (vin >= int'(sar_code)) : wobble;
    end
endmodule

// File: verification/tb_adc_conversion_control.sv
`timescale 1ns/1ps
module tb_adc_conversion_control;
    import acc_pkg::*;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       stop = 1'b0;
    logic [3:0] pin_in = 4'h0;
    logic       comp_hi;
    logic [7:0] rdata;
    logic [7:0] sar_code;
    logic [4:0] chan_sel;
    logic       conv_en;
    logic       conv_irq;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    int         lvl [4] = '{10, 126, -20, 300};
    logic [4:0] chs [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1d, 5'h1e};
    logic [7:0] res [6] = '{8'h0a, 8'h7e, 8'h00, 8'hff, 8'hff, 8'h00};
    int         mismatches = 0;
    int         tests_run = 0;
    logic [7:0] d;
    int         n;
    int         dv;

    always #20 clk = ~clk;

    acc_top u_dut (
        .CORE_CLK (clk), .NRST (nrst), .ADDR (addr), .WDATA (wdata), .WR (wr), .RD (rd),
        .RDATA (rdata), .STOP_MODE (stop), .COMP_HI (comp_hi), .SAR_CODE (sar_code),
        .CHAN_SEL (chan_sel), .CONV_EN (conv_en), .CONV_IRQ (conv_irq), .PIN_IN (pin_in),
        .PIN_OUT (pin_out), .PIN_OE (pin_oe), .STATE_UNUSED_NONE (ST_IDLE)
    );
    acc_comparator_model u_cmp (
        .clk (clk), .sar_code (sar_code), .chan_sel (chan_sel), .conv_en (conv_en),
        .level (lvl), .comp_hi (comp_hi)
    );

    // ======================================
    // bus and check tasks
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask
    task automatic wait_done();
        d = 8'h00;
        for (int i = 0; i < 400 && d[7] !== 1'b1; i++) rd_reg(8'h3c, d);
        chk("done flag", {7'h0, d[7]}, 8'h01);
    endtask
    task automatic wait_irq();
        n = 0;
        while (conv_irq !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask
    task automatic summarize();
        if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ======================================
    // sequence
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd_reg(8'h3c, d); chk("csr reset", d, 8'h1f);
        rd_reg(8'h3f, d); chk("prescale reset", d, 8'h00);
        rd_reg(8'h55, d); chk("unmapped read", d, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr_reg(8'h3c, {3'h0, chs[i]});
            wait_done();
            rd_reg(8'h3e, d); chk("result", d, res[i]);
            rd_reg(8'h3c, d); chk("flag cleared", d, {3'h0, chs[i]});
        end
        for (int p = 0; p < 8; p++) begin
            dv = p[2] ? 16 : (1 << p);
            wr_reg(8'h3f, 8'(p));
            wr_reg(8'h3c, 8'h41);
            wait_irq();
            chk("conversion time", 8'(n >= 16 * dv && n <= 17 * dv + 4), 8'h01);
            rd_reg(8'h3c, d); chk("flag with irq on", d, 8'h41);
            rd_reg(8'h3e, d); chk("irq result", d, 8'h7e);
            chk("irq after read", {7'h0, conv_irq}, 8'h00);
        end
        wr_reg(8'h3c, 8'h41);
        wait_irq();
        chk("irq raised", {7'h0, conv_irq}, 8'h01);
        wr_reg(8'h3c, 8'h41);
        chk("irq after write", {7'h0, conv_irq}, 8'h00);
        wr_reg(8'h3f, 8'h00);
        // result of the aborted conversion is never read
        wr_reg(8'h3c, 8'h20);
        wait_done();
        rd_reg(8'h3e, d); chk("cont first", d, 8'h0a);
        lvl[0] <= 200;
        repeat (60) @(posedge clk);
        rd_reg(8'h3c, d); chk("flag kept", d, 8'ha0);
        rd_reg(8'h3e, d); chk("cont overwrite", d, 8'hc8);
        wr_reg(8'h3c, 8'h00);
        // a continuous pass may have set the flag just before the write
        rd_reg(8'h3e, d);
        wait_done();
        rd_reg(8'h3e, d); chk("single result", d, 8'hc8);
        repeat (60) @(posedge clk);
        rd_reg(8'h3c, d); chk("single stops", d, 8'h00);
        chk("sar idle", sar_code, 8'h00);
        wr_reg(8'h3f, 8'h04);
        lvl[0] <= 50;
        wr_reg(8'h3c, 8'h00);
        repeat (100) @(posedge clk);
        stop <= 1'b1;
        repeat (300) @(posedge clk);
        rd_reg(8'h3e, d); chk("result held in stop", d, 8'hc8);
        rd_reg(8'h3c, d); chk("no flag in stop", d, 8'h00);
        stop <= 1'b0;
        wait_done();
        // the first result after stop is still settling and is dropped
        rd_reg(8'h3e, d);
        wr_reg(8'h3c, 8'h00);
        wait_done();
        rd_reg(8'h3e, d); chk("after stop", d, 8'h32);
        wr_reg(8'h3c, 8'h01);
        wr_reg(8'h00, 8'h0a);
        wr_reg(8'h04, 8'h0f);
        pin_in <= 4'hf;
        chk("pin drive", {4'h0, pin_oe}, 8'h0d);
        chk("pin latch", {4'h0, pin_out}, 8'h0a);
        rd_reg(8'h00, d); chk("port read latch", d, 8'h0a);
        wr_reg(8'h04, 8'h00);
        repeat (4) @(posedge clk);
        rd_reg(8'h00, d); chk("port read input", d, 8'h0d);
        wr_reg(8'h3c, 8'h1f);
        chk("power off", {7'h0, conv_en}, 8'h00);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule
